// ==== hw/hcs_pkg.sv ====
// shared offsets, field positions, reset values and timing counts for the system csr block
package hcs_pkg;

	// register byte offsets on the host bus
	localparam logic [7:0] OFF_TIMER_CONFIG = 8'h8C;
	localparam logic [7:0] OFF_TIMER_VALUE = 8'h90;
	localparam logic [7:0] OFF_HALF_ORDER = 8'h98;
	localparam logic [7:0] OFF_TICK_COUNTER = 8'h9C;
	localparam logic [7:0] OFF_DISCARD = 8'hA0;
	localparam logic [7:0] OFF_MAC_CMD = 8'hA4;
	localparam logic [7:0] OFF_MAC_VALUE = 8'hA8;

	// field positions inside the upper halfword of a 32-bit register
	localparam int TCFG_RUN_BIT_HI = 13;
	localparam int MCMD_BUSY_BIT_HI = 15;
	localparam int MCMD_RNW_BIT_HI = 14;

	// field widths
	localparam int PRELOAD_W = 16;
	localparam int MAC_ADDR_W = 8;
	localparam int TICK_CNT_W = 10;

	// reset and marker values
	localparam logic [15:0] TIMER_PRELOAD_RST = 16'hFFFF;
	localparam logic [15:0] TIMER_VALUE_RST = 16'hFFFF;
	localparam logic [31:0] HALF_ORDER_RST = 32'h00000000;
	localparam logic [31:0] HALF_ORDER_SWAP = 32'hFFFFFFFF;
	localparam logic [31:0] DISCARD_RST = 32'h00000000;
	localparam logic [31:0] DISCARD_HALF_FROM = 32'h7FFFFFFF;
	localparam logic [31:0] HALF_LOW_MASK = 32'h0000FFFF;
	localparam logic [31:0] HALF_HIGH_MASK = 32'hFFFF0000;

	// timing: 10 MHz system clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIMER_TICK_NS = 100000;
	localparam int TIMER_TICK_CYC = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [TICK_CNT_W-1:0] TIMER_TICK_LAST = TICK_CNT_W'(TIMER_TICK_CYC - 1);
	localparam int TICK_CLEAR_NS = 160;
	localparam int TICK_CLEAR_CYC = (TICK_CLEAR_NS / CLK_PERIOD_NS) < 1 ? 1 :
		(TICK_CLEAR_NS / CLK_PERIOD_NS);

	// 25 MHz on a 10 MHz clock: add 2 and 3 in turn, 2.5 per cycle
	localparam logic [31:0] TICK_STEP_A = 32'h00000002;
	localparam logic [31:0] TICK_STEP_B = 32'h00000003;

	// event flag positions
	localparam int EVT_TIMER = 0;
	localparam int EVT_DISCARD = 1;
	localparam int EVT_N = 2;

	typedef enum logic [0:0] {
		HCS_MAC_IDLE = 1'b0,
		HCS_MAC_BUSY = 1'b1
	} hcs_mac_state_type;

endpackage : hcs_pkg

// ==== hw/hcs_interval_timer.sv ====
// prescaled 16-bit down counter that reloads and pulses on each interval
`timescale 1ns/1ps
`default_nettype none

module hcs_interval_timer (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// control
	input wire logic run_in,
	input wire logic [hcs_pkg::PRELOAD_W-1:0] preload_in,
	// status
	output logic [hcs_pkg::PRELOAD_W-1:0] value_out,
	output logic expire_out
);

	typedef struct packed {
		logic [hcs_pkg::TICK_CNT_W-1:0] prescale;
		logic [hcs_pkg::PRELOAD_W-1:0] count;
		logic run_q;
		logic expire;
	} hcs_timer_state_type;

	hcs_timer_state_type st_r;
	hcs_timer_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.run_q = run_in;
		st_nxt.expire = 1'b0;
		if (run_in && !st_r.run_q) begin
			st_nxt.count = preload_in; // R3
			st_nxt.prescale = '0;
		end else if (run_in) begin // R1
			if (st_r.prescale == hcs_pkg::TIMER_TICK_LAST) begin
				st_nxt.prescale = '0;
				if (st_r.count == '0) begin
					st_nxt.count = preload_in; // R5
					st_nxt.expire = 1'b1; // R4
				end else begin
					st_nxt.count = st_r.count - 16'h0001; // R5
				end
			end else begin
				st_nxt.prescale = st_r.prescale + 10'h001;
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r.prescale <= '0;
			st_r.count <= hcs_pkg::TIMER_VALUE_RST; // R6
			st_r.run_q <= 1'b0;
			st_r.expire <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value_out = st_r.count;
	assign expire_out = st_r.expire;

endmodule : hcs_interval_timer

`default_nettype wire

// ==== hw/hcs_system_csr.sv ====
// host system csr block: timer, halfword order, tick and discard counters, indirect mac access
//
// How it works
// (R1) writing one to timer run bit starts the interval timer; zero halts it
// (R2) run bit falling from one to zero forces the preload field to FFFFh
// (R3) preload sits in config bits 15-0, resets FFFFh, is the timer start count
// (R4) a running timer raises a periodic event at the preload-set interval
// (R5) each tick decrements; past zero it flags the event and reloads preload
// (R6) timer count register bits 15-0 read the live timer value, reset all ones
// (R7) order not all ones: address bit one high selects upper halves
// (R8) order all ones: address bit one high selects lower halves
// (R9) network side always sends and fills queue words lower half first
// (R10) 32-bit tick counter starts at zero, counts at 25 MHz, wraps
// (R11) first halfword read latches the whole count; the second reads the copy
// (R12) tick counter may take up to 160 ns to read zero after reset
// (R13) tick counter runs in every power state, never gated
// (R14) discard counter adds one for every frame the receiver drops
// (R15) any read returns then clears the discard counter; resets to zero; here only the first halfword read of a pair clears it
// (R16) discard counter crossing 7FFFFFFFh to 80000000h raises an event
// (R17) timer and discard events set sticky flags, enabled onto one interrupt
// (R18) command bit 31 starts the indirect access, stays set until it completes
// (R19) read data is in the value register by the time busy clears
// (R20) host must not write command or value registers while busy
// (R21) command bit 30 picks direction: one reads, zero writes; resets zero
// (R22) command bits 7-0 address the internal mac register
// (R23) 32-bit value register at A8h holds write data or returned read data
`timescale 1ns/1ps
`default_nettype none

module hcs_system_csr (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// host sram-like bus, asynchronous pins
	input wire logic host_cs_n_in,
	input wire logic host_rd_n_in,
	input wire logic host_wr_n_in,
	input wire logic [7:1] host_addr_in,
	input wire logic [15:0] host_data_in,
	output logic [15:0] host_data_out,
	output logic host_data_oe_n_out,
	// receiver
	input wire logic frame_discard_in,
	// internal mac register port
	output logic mac_req_out,
	output logic mac_read_out,
	output logic [hcs_pkg::MAC_ADDR_W-1:0] mac_addr_out,
	output logic [31:0] mac_wdata_out,
	input wire logic mac_done_in,
	input wire logic [31:0] mac_rdata_in,
	// data queue halfword order
	output logic host_half_swap_out,
	// events
	input wire logic [hcs_pkg::EVT_N-1:0] irq_enable_in,
	input wire logic [hcs_pkg::EVT_N-1:0] irq_clear_in,
	output logic [hcs_pkg::EVT_N-1:0] irq_status_out,
	output logic irq_out
);

	typedef struct packed {
		logic [2:0] strb_s1;
		logic [2:0] strb_s2;
		logic [2:0] strb_s3;
		logic [7:1] addr_s1;
		logic [7:1] addr_s2;
		logic [15:0] data_s1;
		logic [15:0] data_s2;
		logic run;
		logic [hcs_pkg::PRELOAD_W-1:0] preload;
		logic [31:0] half_order;
		logic [31:0] tick_cnt;
		logic tick_phase;
		logic [31:0] tick_copy;
		logic tick_held;
		logic [31:0] discard;
		logic [31:0] discard_copy;
		logic discard_held;
		hcs_pkg::hcs_mac_state_type mac_state;
		logic mac_rnw;
		logic [hcs_pkg::MAC_ADDR_W-1:0] mac_addr;
		logic [31:0] mac_value;
		logic [15:0] rdata;
		logic [hcs_pkg::EVT_N-1:0] flags;
		logic irq;
	} hcs_csr_state_type;

	hcs_csr_state_type st_r;
	hcs_csr_state_type st_nxt;

	logic [hcs_pkg::PRELOAD_W-1:0] timer_value;
	logic timer_expire;
	logic swap_all;
	logic hi_half;
	logic [7:0] word_off;
	logic rd_now;
	logic rd_was;
	logic wr_now;
	logic wr_was;
	logic rd_take;
	logic wr_take;
	logic [31:0] rd_word;
	logic [31:0] wmask;
	logic [31:0] wword;
	logic disc_rd;
	logic disc_half;
	logic [hcs_pkg::EVT_N-1:0] events;
	logic mac_busy;

	hcs_interval_timer u_timer (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.run_in(st_r.run),
		.preload_in(st_r.preload),
		.value_out(timer_value),
		.expire_out(timer_expire)
	);

	// strobes: [2] chip select, [1] read, [0] write, all active low
	always_comb begin
		rd_now = !st_r.strb_s2[2] && !st_r.strb_s2[1];
		rd_was = !st_r.strb_s3[2] && !st_r.strb_s3[1];
		wr_now = !st_r.strb_s2[2] && !st_r.strb_s2[0];
		wr_was = !st_r.strb_s3[2] && !st_r.strb_s3[0];
		rd_take = rd_now && !rd_was;
		wr_take = wr_now && !wr_was;
		swap_all = (st_r.half_order == hcs_pkg::HALF_ORDER_SWAP);
		hi_half = st_r.addr_s2[1] ^ swap_all; // R7 R8
		word_off = {st_r.addr_s2[7:2], 2'b00};
		wmask = hi_half ? hcs_pkg::HALF_HIGH_MASK : hcs_pkg::HALF_LOW_MASK;
		wword = {st_r.data_s2, st_r.data_s2};
		mac_busy = (st_r.mac_state == hcs_pkg::HCS_MAC_BUSY);
		disc_rd = rd_take && (word_off == hcs_pkg::OFF_DISCARD) && !st_r.discard_held;
		disc_half = frame_discard_in && !disc_rd &&
			(st_r.discard == hcs_pkg::DISCARD_HALF_FROM); // R16
		events = '0;
		events[hcs_pkg::EVT_TIMER] = timer_expire;
		events[hcs_pkg::EVT_DISCARD] = disc_half;
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rd_word = '0;
		if (word_off == hcs_pkg::OFF_TIMER_CONFIG) begin
			rd_word[hcs_pkg::PRELOAD_W-1:0] = st_r.preload;
			rd_word[hcs_pkg::TCFG_RUN_BIT_HI + 16] = st_r.run;
		end else if (word_off == hcs_pkg::OFF_TIMER_VALUE) begin
			rd_word[hcs_pkg::PRELOAD_W-1:0] = timer_value; // R6
		end else if (word_off == hcs_pkg::OFF_HALF_ORDER) begin
			rd_word = st_r.half_order;
		end else if (word_off == hcs_pkg::OFF_TICK_COUNTER) begin
			rd_word = st_r.tick_held ? st_r.tick_copy : st_r.tick_cnt; // R11
		end else if (word_off == hcs_pkg::OFF_DISCARD) begin
			rd_word = st_r.discard_held ? st_r.discard_copy : st_r.discard;
		end else if (word_off == hcs_pkg::OFF_MAC_CMD) begin
			rd_word[hcs_pkg::MCMD_BUSY_BIT_HI + 16] = mac_busy;
			rd_word[hcs_pkg::MCMD_RNW_BIT_HI + 16] = st_r.mac_rnw;
			rd_word[hcs_pkg::MAC_ADDR_W-1:0] = st_r.mac_addr;
		end else if (word_off == hcs_pkg::OFF_MAC_VALUE) begin
			rd_word = st_r.mac_value;
		end
	end

	always_comb begin
		st_nxt = st_r;
		// pins pass two flops; the third stage serves edge detection and the read output enable
		st_nxt.strb_s1 = {host_cs_n_in, host_rd_n_in, host_wr_n_in};
		st_nxt.strb_s2 = st_r.strb_s1;
		st_nxt.strb_s3 = st_r.strb_s2;
		st_nxt.addr_s1 = host_addr_in;
		st_nxt.addr_s2 = st_r.addr_s1;
		st_nxt.data_s1 = host_data_in;
		st_nxt.data_s2 = st_r.data_s1;

		// never gated by any power state input: there is none to gate it
		st_nxt.tick_phase = !st_r.tick_phase; // R13
		st_nxt.tick_cnt = st_r.tick_cnt +
			(st_r.tick_phase ? hcs_pkg::TICK_STEP_B : hcs_pkg::TICK_STEP_A); // R10

		// a drop in the clearing cycle counts into the fresh zero
		st_nxt.discard = (disc_rd ? hcs_pkg::DISCARD_RST : st_r.discard) +
			{31'h00000000, frame_discard_in}; // R14 R15

		if (rd_take) begin
			st_nxt.rdata = hi_half ? rd_word[31:16] : rd_word[15:0];
			if (word_off == hcs_pkg::OFF_TICK_COUNTER) begin
				st_nxt.tick_copy = st_r.tick_cnt; // R11
				st_nxt.tick_held = !st_r.tick_held;
			end
			if (word_off == hcs_pkg::OFF_DISCARD) begin
				st_nxt.discard_copy = st_r.discard; // R15
				st_nxt.discard_held = !st_r.discard_held;
			end
		end

		if (wr_take) begin
			if (word_off == hcs_pkg::OFF_TIMER_CONFIG) begin
				if (hi_half) begin
					st_nxt.run = st_r.data_s2[hcs_pkg::TCFG_RUN_BIT_HI]; // R1
					if (st_r.run && !st_r.data_s2[hcs_pkg::TCFG_RUN_BIT_HI]) begin
						st_nxt.preload = hcs_pkg::TIMER_PRELOAD_RST; // R2
					end
				end else begin
					st_nxt.preload = st_r.data_s2; // R3
				end
			end else if (word_off == hcs_pkg::OFF_HALF_ORDER) begin
				st_nxt.half_order = (st_r.half_order & ~wmask) | (wword & wmask);
			end else if (word_off == hcs_pkg::OFF_MAC_CMD && !mac_busy) begin // R20
				if (hi_half) begin
					st_nxt.mac_rnw = st_r.data_s2[hcs_pkg::MCMD_RNW_BIT_HI]; // R21
					if (st_r.data_s2[hcs_pkg::MCMD_BUSY_BIT_HI]) begin
						st_nxt.mac_state = hcs_pkg::HCS_MAC_BUSY; // R18
					end
				end else begin
					st_nxt.mac_addr = st_r.data_s2[hcs_pkg::MAC_ADDR_W-1:0]; // R22
				end
			end else if (word_off == hcs_pkg::OFF_MAC_VALUE && !mac_busy) begin // R20
				st_nxt.mac_value = (st_r.mac_value & ~wmask) | (wword & wmask); // R23
			end
		end

		case (st_r.mac_state)
			hcs_pkg::HCS_MAC_IDLE: begin
				// a stray done while idle is ignored, nothing is pending
			end
			hcs_pkg::HCS_MAC_BUSY: begin
				if (mac_done_in) begin
					st_nxt.mac_state = hcs_pkg::HCS_MAC_IDLE; // R18
					if (st_r.mac_rnw) begin
						st_nxt.mac_value = mac_rdata_in; // R19
					end
				end
			end
			default: begin
				st_nxt.mac_state = hcs_pkg::HCS_MAC_IDLE;
			end
		endcase

		// set wins over clear
		st_nxt.flags = (st_r.flags & ~irq_clear_in) | events; // R17
		st_nxt.irq = |(st_nxt.flags & irq_enable_in); // R17
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
			st_r.strb_s1 <= 3'h7;
			st_r.strb_s2 <= 3'h7;
			st_r.strb_s3 <= 3'h7;
			st_r.preload <= hcs_pkg::TIMER_PRELOAD_RST; // R3
			st_r.half_order <= hcs_pkg::HALF_ORDER_RST;
			st_r.tick_cnt <= '0; // R10 R12
			st_r.discard <= hcs_pkg::DISCARD_RST; // R15
			st_r.mac_state <= hcs_pkg::HCS_MAC_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// data is registered at the take edge, so drive from the cycle after it
	assign host_data_oe_n_out = !rd_was;
	assign host_data_out = st_r.rdata;
	assign mac_req_out = mac_busy; // R18
	assign mac_read_out = st_r.mac_rnw; // R21
	assign mac_addr_out = st_r.mac_addr; // R22
	assign mac_wdata_out = st_r.mac_value; // R23
	// swap only steers host-side halves; queue-to-network order ignores it
	assign host_half_swap_out = swap_all; // R9
	assign irq_status_out = st_r.flags;
	assign irq_out = st_r.irq;

	// one clock domain: all checks are off while reset is low
	default clocking chk_cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	sequence s_run_stop;
		$fell(st_r.run);
	endsequence

	sequence s_mac_start;
		!mac_busy ##1 mac_busy;
	endsequence

	sequence s_mac_read_end;
		mac_busy && st_r.mac_rnw && mac_done_in;
	endsequence

	chk_run_stop_preload: assert property (s_run_stop |-> st_r.preload == 16'hFFFF) // R2
		else $error("preload not forced to all ones when timer stopped");

	chk_tick_step_rate: assert property ( // R10
		$past(nrst_in) |-> (st_r.tick_cnt == $past(st_r.tick_cnt) + 32'h2 ||
			st_r.tick_cnt == $past(st_r.tick_cnt) + 32'h3))
		else $error("tick counter step is not two or three");

	chk_tick_reset_zero: assert property ($rose(nrst_in) |-> st_r.tick_cnt == 32'h0) // R12
		else $error("tick counter not zero after reset");

	chk_discard_count_up: assert property (frame_discard_in && !disc_rd |=> // R14
		st_r.discard == $past(st_r.discard) + 32'h1)
		else $error("discard counter did not count a dropped frame");

	chk_discard_read_clear: assert property (disc_rd |=> // R15
		st_r.discard == {31'h0, $past(frame_discard_in)})
		else $error("discard counter not cleared by read");

	chk_discard_half_flag: assert property (st_r.discard == 32'h7FFFFFFF && // R16
		frame_discard_in && !disc_rd |=> st_r.flags[hcs_pkg::EVT_DISCARD] &&
		(st_r.irq || !$past(irq_enable_in[hcs_pkg::EVT_DISCARD])))
		else $error("halfway crossing did not set its flag");

	chk_mac_busy_hold: assert property (s_mac_start ##0 !mac_done_in |=> mac_busy) // R18
		else $error("busy dropped before completion");

	chk_mac_read_data: assert property (s_mac_read_end |=> // R19
		!mac_busy && st_r.mac_value == $past(mac_rdata_in))
		else $error("read data not in place when busy cleared");

	chk_timer_flag_set: assert property (timer_expire |=> st_r.flags[0]) // R17
		else $error("timer event did not set its flag");

	chk_irq_follows_flags: assert property ( // R17
		st_r.irq == |(st_r.flags & $past(irq_enable_in)))
		else $error("interrupt output disagrees with enabled flags");

	chk_mac_hold_fields: assert property (mac_busy && !mac_done_in |=> // R18
		$stable(mac_addr_out) && $stable(mac_read_out) &&
		$stable(mac_wdata_out))
		else $error("indirect request fields moved while busy");

	chk_timer_halt_hold: assert property (!$past(st_r.run) |-> $stable(timer_value)) // R1
		else $error("halted timer count moved");

	chk_tick_latch_copy: assert property (rd_take && !st_r.tick_held && // R11
		word_off == hcs_pkg::OFF_TICK_COUNTER |=> st_r.tick_copy == $past(st_r.tick_cnt))
		else $error("tick count not latched on first halfword read");

	chk_half_select_map: assert property (wr_take && word_off == 8'h98 |=> // R7
		(st_r.half_order & ($past(hi_half) ? 32'hFFFF0000 : 32'h0000FFFF)) ==
		({$past(st_r.data_s2), $past(st_r.data_s2)} &
		($past(hi_half) ? 32'hFFFF0000 : 32'h0000FFFF)))
		else $error("halfword write landed in the wrong half");

endmodule : hcs_system_csr

`default_nettype wire

// ==== testbench/hcs_mac_model.sv ====
// behavioural model of the internal mac register file behind the indirect port
`timescale 1ns/1ps
`default_nettype none

module hcs_mac_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// indirect port from the csr block
	input wire logic req_in,
	input wire logic read_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic [31:0] lat_in,
	output logic done_out,
	output logic [31:0] rdata_out
);
	logic [31:0] regs [256];
	int wait_cnt;
	initial begin
		for (int i = 0; i < 256; i++) regs[i] = 32'h00000000;
	end
	// outside the done cycle the data lines show the inverse, never a stale match
	assign rdata_out = done_out ? regs[addr_in] : ~regs[addr_in];
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			done_out <= 1'b0;
			wait_cnt <= 0;
		end else if (done_out) begin
			done_out <= 1'b0;
			wait_cnt <= 0;
		end else if (req_in) begin
			wait_cnt <= wait_cnt + 1;
			if (wait_cnt >= lat_in) begin
				done_out <= 1'b1;
				if (!read_in) regs[addr_in] <= wdata_in;
			end
		end
	end
endmodule : hcs_mac_model
`default_nettype wire

// ==== testbench/hcs_system_csr_test.sv ====
// self-checking bench for the host system csr block
`timescale 1ns/1ps
`default_nettype none

module hcs_system_csr_test;
	logic clk_in, nrst_in, cs_n, rd_n, wr_n, discard, mac_done, oe_n, mac_req, mac_read, swap, irq;
	logic [7:1] addr;
	logic [15:0] wdata, dpin, h;
	logic [7:0] mac_addr, a;
	logic [31:0] mac_wdata, mac_rdata, v, d, seed;
	logic [1:0] irq_en, irq_clr, irq_sts;
	logic [31:0] mac_ref [int];
	int err_total, checks_done, mac_lat, n, cyc, c;
	logic [7:0] offs [7] = '{8'h8C, 8'h90, 8'h98, 8'hA4, 8'hA8, 8'hA0, 8'h80};
	logic [31:0] rstv [7] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	hcs_system_csr hcs_system_csr_i (.clk_in(clk_in), .nrst_in(nrst_in), .host_cs_n_in(cs_n),
		.host_rd_n_in(rd_n), .host_wr_n_in(wr_n), .host_addr_in(addr), .host_data_in(wdata),
		.host_data_out(dpin), .host_data_oe_n_out(oe_n), .frame_discard_in(discard),
		.mac_req_out(mac_req), .mac_read_out(mac_read), .mac_addr_out(mac_addr),
		.mac_wdata_out(mac_wdata), .mac_done_in(mac_done), .mac_rdata_in(mac_rdata),
		.host_half_swap_out(swap), .irq_enable_in(irq_en), .irq_clear_in(irq_clr),
		.irq_status_out(irq_sts), .irq_out(irq));
	hcs_mac_model hcs_mac_model_i (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(mac_req),
		.read_in(mac_read), .addr_in(mac_addr), .wdata_in(mac_wdata), .lat_in(mac_lat),
		.done_out(mac_done), .rdata_out(mac_rdata));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	always @(posedge clk_in) cyc <= cyc + 1;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic hrd(input logic [7:0] off, output logic [15:0] q);
		int i;
		@(negedge clk_in);
		addr = off[7:1];
		cs_n = 1'b0;
		rd_n = 1'b0;
		for (i = 0; i < 12; i++) begin
			@(posedge clk_in);
			#1;
			if (oe_n === 1'b0) break;
		end
		if (i == 12) check(1'b0, 1'b1, "read timeout");
		if (i == 12) wrap_up();
		q = dpin;
		@(negedge clk_in);
		cs_n = 1'b1;
		rd_n = 1'b1;
		repeat (4) @(posedge clk_in);
	endtask : hrd

	task automatic hwr(input logic [7:0] off, input logic [15:0] q);
		@(negedge clk_in);
		addr = off[7:1];
		wdata = q;
		cs_n = 1'b0;
		wr_n = 1'b0;
		repeat (4) @(posedge clk_in);
		@(negedge clk_in);
		cs_n = 1'b1;
		wr_n = 1'b1;
		repeat (4) @(posedge clk_in);
	endtask : hwr

	task automatic rd32(input logic [7:0] off, output logic [31:0] q);
		hrd(off, q[15:0]);
		hrd(off + 8'h02, q[31:16]);
	endtask : rd32

	task automatic wait_idle();
		for (int i = 0; i < 20; i++) begin
			hrd(8'hA6, h);
			if (h[15] === 1'b0) return;
		end
		check(1'b0, 1'b1, "busy timeout");
		wrap_up();
	endtask : wait_idle

	task automatic wait_irq(output int k);
		for (k = 0; k < 4000; k++) begin
			@(posedge clk_in);
			#1;
			if (irq === 1'b1) break;
		end
		if (k == 4000) check(1'b0, 1'b1, "irq timeout");
		if (k == 4000) wrap_up();
	endtask : wait_irq

	initial begin
		{cs_n, rd_n, wr_n} = 3'b111;
		{discard, irq_en, irq_clr, addr, wdata} = '0;
		seed = 32'h445C;
		mac_lat = 0;
		nrst_in = 1'b0;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		nrst_in = 1'b1;
		cyc = 0;
		for (int i = 0; i < 7; i++) begin
			rd32(offs[i], v);
			check(v, rstv[i], "reset value");
		end
		// tick count read as a latched pair, near 2.5 counts per cycle
		n = cyc;
		rd32(8'h9C, v);
		check(v > 5 * n / 2 - 32 && v < 5 * n / 2 + 32, 1'b1, "tick count");
		n = rnd() % 20 + 1;
		for (int i = 0; i < n; i++) begin
			@(negedge clk_in) discard = 1'b1;
			@(negedge clk_in) discard = 1'b0;
		end
		rd32(8'hA0, v);
		check(v, n, "discard tally");
		rd32(8'hA0, v);
		check(v, 32'h0, "discard cleared");
		hwr(8'h98, 16'hFFFF);
		hwr(8'h9A, 16'hFFFF);
		check(swap, 1'b1, "swap on");
		hrd(8'h8C, h);
		check(h, 16'h0000, "swapped upper");
		hrd(8'h8E, h);
		check(h, 16'hFFFF, "swapped lower");
		hwr(8'h98, 16'h0000);
		hwr(8'h98, 16'h0000);
		check(swap, 1'b0, "swap off");
		hrd(8'h8E, h);
		check(h, 16'h0000, "plain upper");
		for (int k = 0; k < 4; k++) begin
			mac_lat = rnd() % 6;
			d = rnd();
			a = d[7:0];
			d = rnd();
			hwr(8'hA8, d[15:0]);
			hwr(8'hAA, d[31:16]);
			hwr(8'hA4, {8'h00, a});
			hwr(8'hA6, 16'h8000);
			mac_ref[a] = d;
			wait_idle();
			hwr(8'hA8, ~d[15:0]);
			hwr(8'hAA, ~d[31:16]);
			hwr(8'hA6, 16'hC000);
			wait_idle();
			rd32(8'hA8, v);
			check(v, mac_ref[a], "indirect read");
		end
		@(negedge clk_in) irq_en = 2'b01;
		hwr(8'h8C, 16'h0002);
		hwr(8'h8E, 16'h2000);
		wait_irq(c);
		check(c < 3100, 1'b1, "first interval");
		@(negedge clk_in) irq_clr = 2'b01;
		@(negedge clk_in) irq_clr = 2'b00;
		check(irq_sts, 2'b00, "flag cleared");
		wait_irq(c);
		check(c > 2990 && c < 3002, 1'b1, "interval length");
		hrd(8'h90, h);
		check(h <= 16'h0002, 1'b1, "live count");
		hwr(8'h8E, 16'h0000);
		hrd(8'h8C, h);
		check(h, 16'hFFFF, "preload forced");
		hrd(8'h90, h);
		repeat (1500) @(posedge clk_in);
		hrd(8'h90, v[15:0]);
		check(v[15:0], h, "halted holds");
		wrap_up();
	end
endmodule : hcs_system_csr_test
`default_nettype wire
